// File: rtl/scc_params.svh
/*
  scc_params.svh: addresses, bit positions, reset values and
  timing counts of the sync, clamp and coast control block.
  assumes a 200 MHz ref_clk; definitions only.
*/
`ifndef SCC_PARAMS_SVH
`define SCC_PARAMS_SVH
// ----------------------------------------
// timing
// ----------------------------------------
`define SCC_CLK_NS       5
`define SCC_SEP_TICK_NS  200
`define SCC_SEP_TICK_CYC (`SCC_SEP_TICK_NS / `SCC_CLK_NS)
`define SCC_DET_WIN_NS   655360
`define SCC_DET_WIN_CYC  (`SCC_DET_WIN_NS / `SCC_CLK_NS)
`define SCC_ACT_W        24
`define SCC_RUN_W        16
// ----------------------------------------
// register addresses
// ----------------------------------------
`define SCC_A_SYNC   8'h0e
`define SCC_A_CCP    8'h0f
`define SCC_A_SLICE  8'h10
`define SCC_A_SEP    8'h11
`define SCC_A_LEAD   8'h12
`define SCC_A_TRAIL  8'h13
`define SCC_A_STAT   8'h14
// ----------------------------------------
// reset values
// ----------------------------------------
`define SCC_R_SYNC   8'h00
`define SCC_R_CCP    8'h4e
`define SCC_R_SLICE  8'hb8
`define SCC_R_SEP    8'h20
`define SCC_R_LEAD   8'h00
`define SCC_R_TRAIL  8'h00
// ----------------------------------------
// bit positions
// ----------------------------------------
`define SCC_B_HPOL   5
`define SCC_B_HOVR   4
`define SCC_B_HSEL   3
`define SCC_B_VNINV  2
`define SCC_B_VOVR   1
`define SCC_B_VSEL   0
`define SCC_B_CLSRC  7
`define SCC_B_CLPOL  6
`define SCC_B_COSEL  5
`define SCC_B_COOVR  4
`define SCC_B_COPOL  3
`define SCC_B_SEEK   2
`define SCC_B_SLEEP  1
`define SCC_B_SLC_HI 7
`define SCC_B_SLC_LO 3
`endif

// File: rtl/scc_pin_watch.sv
/*
  scc_pin_watch: three-flop synchroniser for one sync pin, plus
  activity detect and idle-level estimate.
  assumes the pin is asynchronous to ref_clk.
*/
`timescale 1ns/100ps
`default_nettype none
module scc_pin_watch #(
  parameter int WIN = `SCC_DET_WIN_CYC // activity window, cycles
) (
  input  wire logic ref_clk,
  input  wire logic rst_n,
  input  wire logic pin,
  output logic      lvl,
  output logic      active,
  output logic      idle_high
);
  import scc_pkg::*;
  scc_pin_st_t s, next_s;

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    next_s    = s;
    next_s.s1 = pin;
    next_s.s2 = s.s1;
    next_s.s3 = s.s2;
    next_s.prev = s.lvl;
    // change counts once flop 2 and 3 agree
    if (s.s2 == s.s3) begin
      next_s.lvl = s.s3;
    end
    if (s.lvl != s.prev) begin
      next_s.act_cnt = `SCC_ACT_W'(WIN);
      next_s.run     = '0;
      // remember length of the run just ended
      if (s.prev) begin
        next_s.hi_len = s.run;
      end else begin
        next_s.lo_len = s.run;
      end
    end else begin
      if (s.act_cnt != '0) begin
        next_s.act_cnt = s.act_cnt - 1'b1;
      end
      if (s.run != '1) begin
        next_s.run = s.run + 1'b1;
      end
    end
  end

  // ----------------------------------------
  // state register
  // ----------------------------------------
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign lvl       = s.lvl;
  assign active    = (s.act_cnt != '0);
  // longer run is the idle level
  assign idle_high = (s.hi_len > s.lo_len);
endmodule // scc_pin_watch
`default_nettype wire

// File: rtl/scc_pkg.sv
/*
  scc_pkg: state types of the sync, clamp and coast block.
  assumes scc_params.svh is on the include path.
*/
`include "scc_params.svh"
package scc_pkg;
  // clamp generator states, one-hot
  typedef enum logic [2:0] {
    SCC_CL_IDLE = 3'h1,
    SCC_CL_WAIT = 3'h2,
    SCC_CL_ON   = 3'h4
  } scc_clamp_st_t;
  // pin watcher state
  typedef struct packed {
    logic                  s1, s2, s3, lvl, prev;
    logic [`SCC_ACT_W-1:0] act_cnt;
    logic [`SCC_RUN_W-1:0] run, hi_len, lo_len;
  } scc_pin_st_t;
endpackage : scc_pkg

// File: rtl/scc_sync_ctrl.sv
/*
  scc_sync_ctrl: sync source selection, output polarity, clamp
  and coast control with their register bank.
  assumes a simple register port fed by the serial control port,
  clamp placement/duration from elsewhere, sync pins asynchronous.
*/
// Overview of operation
// - hsync/green outputs: 0 high pulse, 1 low
// - hsync override picks source from select bit
// - select: 0 sync pin, 1 green sync
// - vsync output inverted when bit is 0
// - vsync override uses vsync select bit
// - vsync select: 0 pin, 1 separator
// - source 0: internal clamp from hsync edge
// - source 1: external clamp pin clamps all
// - clamp polarity 1 means active low
// - coast from pin or active vsync
// - coast polarity detected unless override set
// - coast holds clock; polarity bit gives level
// - seek mode allowed only when bit set
// - power-down bit 0 sleeps the device
// - five-bit slicer threshold, default 23
// - per-channel clamp: ground or midscale
// - separator toggles after threshold 5 MHz ticks
// - pre-coast lines before vsync
// - post-coast lines after vsync
// - hsync detect status bit
// - status shows hsync source in use
// - auto vsync: pin if active, else separator
`timescale 1ns/100ps
`default_nettype none
module scc_sync_ctrl #(
  parameter int DET_WIN = `SCC_DET_WIN_CYC // activity window
) (
  input  wire logic       ref_clk,
  input  wire logic       rst_n,
  input  wire logic [7:0] reg_addr,
  input  wire logic       reg_wr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  input  wire logic       hsync_pin,
  input  wire logic       green_embedded_sync_pin,
  input  wire logic       vsync_pin,
  input  wire logic       clamp_pin,
  input  wire logic       coast_pin,
  input  wire logic [7:0] clamp_place,
  input  wire logic [7:0] clamp_len,
  output logic            hsync_out,
  output logic            green_embedded_sync_out,
  output logic            vsync_out,
  output logic            clamp_out,
  output logic      [2:0] clamp_mid,
  output logic      [4:0] slicer_code,
  output logic            coast_out,
  output logic            seek_out,
  output logic            power_down
);
  import scc_pkg::*;

  // ----------------------------------------
  // state
  // ----------------------------------------
  typedef struct packed {
    logic [7:0]    r0e, r0f, r10, r11, r12, r13; // control regs
    logic [7:0]    rdata;                        // read data
    scc_clamp_st_t cst;                          // clamp fsm
    logic [7:0]    ccnt;                         // clamp counter
    logic [5:0]    tick;                         // 5 MHz prescale
    logic [7:0]    sep_cnt;                      // separator count
    logic          sep_out;                      // separator output
    logic          h_prev, v_prev;               // edge memory
    logic [15:0]   line_cnt, frame_len;          // lines per frame
    logic [7:0]    post_cnt;                     // post-coast lines
    logic          hs, gs, vs, cl, co, sk, pd;   // registered outputs
  } scc_st_t;
  scc_st_t s, next_s;

  logic h_lvl, h_act, h_idle, g_lvl, g_act, g_idle;
  logic v_lvl, v_act, v_idle, c_lvl, c_idle, k_lvl;
  logic h_src, v_src, h_norm, g_norm, v_norm, h_lead, v_lead;
  logic pre_on, coast_v, coast_p, co_pol, clamp_x, clamp_i;
  logic [7:0] stat;

  // ----------------------------------------
  // pin watchers
  // ----------------------------------------
  scc_pin_watch #(.WIN(DET_WIN)) u_h (
    .ref_clk(ref_clk), .rst_n(rst_n), .pin(hsync_pin),
    .lvl(h_lvl), .active(h_act), .idle_high(h_idle));
  scc_pin_watch #(.WIN(DET_WIN)) u_g (
    .ref_clk(ref_clk), .rst_n(rst_n), .pin(green_embedded_sync_pin),
    .lvl(g_lvl), .active(g_act), .idle_high(g_idle));
  scc_pin_watch #(.WIN(DET_WIN)) u_v (
    .ref_clk(ref_clk), .rst_n(rst_n), .pin(vsync_pin),
    .lvl(v_lvl), .active(v_act), .idle_high(v_idle));
  scc_pin_watch #(.WIN(DET_WIN)) u_c (
    .ref_clk(ref_clk), .rst_n(rst_n), .pin(coast_pin),
    .lvl(c_lvl), .active(), .idle_high(c_idle));
  scc_pin_watch #(.WIN(DET_WIN)) u_k (
    .ref_clk(ref_clk), .rst_n(rst_n), .pin(clamp_pin),
    .lvl(k_lvl), .active(), .idle_high());

  // ----------------------------------------
  // source selection and status
  // ----------------------------------------
  always_comb begin
    if (s.r0e[`SCC_B_HOVR]) begin
      h_src = s.r0e[`SCC_B_HSEL];
    end else if (h_act != g_act) begin
      h_src = g_act;
    end else begin
      h_src = s.r0e[`SCC_B_HSEL];
    end
    if (s.r0e[`SCC_B_VOVR]) begin
      v_src = s.r0e[`SCC_B_VSEL];
    end else begin
      v_src = !v_act;
    end
    // normalise syncs to active high
    g_norm = g_lvl ^ g_idle;
    h_norm = h_src ? g_norm : (h_lvl ^ h_idle);
    v_norm = v_src ? s.sep_out : (v_lvl ^ v_idle);
    h_lead = h_norm && !s.h_prev;
    v_lead = v_norm && !s.v_prev;
    stat = {h_act, h_src, !h_idle, v_act, v_src,
            s.r0e[`SCC_B_VNINV], g_act, !c_idle};
  end

  // ----------------------------------------
  // coast and clamp sources
  // ----------------------------------------
  always_comb begin
    // predict vsync from last frame length
    // strictly greater: line count hits frame length on the last line
    pre_on  = (s.r12 != 8'h00) && (s.frame_len != 16'h0000) &&
              ((s.line_cnt + 16'(s.r12)) > s.frame_len);
    // hold after vsync for post lines
    coast_v = v_norm || pre_on || (s.post_cnt != 8'h00);
    co_pol  = s.r0f[`SCC_B_COOVR] ? s.r0f[`SCC_B_COPOL] : !c_idle;
    coast_p = (c_lvl == co_pol);
    clamp_x = s.r0f[`SCC_B_CLPOL] ? !k_lvl : k_lvl;
    clamp_i = (s.cst == SCC_CL_ON);
  end

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    next_s        = s;
    next_s.h_prev = h_norm;
    next_s.v_prev = v_norm;
    next_s.rdata  = 8'h00;
    // register writes; status is read-only
    if (reg_wr) begin
      if (reg_addr == `SCC_A_SYNC) begin
        next_s.r0e = reg_wdata;
      end else if (reg_addr == `SCC_A_CCP) begin
        next_s.r0f = reg_wdata;
      end else if (reg_addr == `SCC_A_SLICE) begin
        next_s.r10 = reg_wdata;
      end else if (reg_addr == `SCC_A_SEP) begin
        next_s.r11 = reg_wdata;
      end else if (reg_addr == `SCC_A_LEAD) begin
        next_s.r12 = reg_wdata;
      end else if (reg_addr == `SCC_A_TRAIL) begin
        next_s.r13 = reg_wdata;
      end
    end
    // register reads, unmapped reads zero
    if (reg_rd) begin
      if (reg_addr == `SCC_A_SYNC) begin
        next_s.rdata = s.r0e;
      end else if (reg_addr == `SCC_A_CCP) begin
        next_s.rdata = s.r0f;
      end else if (reg_addr == `SCC_A_SLICE) begin
        next_s.rdata = s.r10;
      end else if (reg_addr == `SCC_A_SEP) begin
        next_s.rdata = s.r11;
      end else if (reg_addr == `SCC_A_LEAD) begin
        next_s.rdata = s.r12;
      end else if (reg_addr == `SCC_A_TRAIL) begin
        next_s.rdata = s.r13;
      end else if (reg_addr == `SCC_A_STAT) begin
        next_s.rdata = stat;
      end
    end
    // separator low-pass on 5 MHz ticks
    if (s.tick == 6'(`SCC_SEP_TICK_CYC - 1)) begin
      next_s.tick = 6'h00;
      if (h_norm == s.sep_out) begin
        next_s.sep_cnt = 8'h00;
      end else if (s.sep_cnt >= s.r11) begin
        next_s.sep_out = h_norm;
        next_s.sep_cnt = 8'h00;
      end else begin
        next_s.sep_cnt = s.sep_cnt + 8'h01;
      end
    end else begin
      next_s.tick = s.tick + 6'h01;
    end
    if (v_lead) begin
      next_s.frame_len = s.line_cnt;
      next_s.line_cnt  = 16'h0000;
    end else if (h_lead && s.line_cnt != 16'hffff) begin
      next_s.line_cnt = s.line_cnt + 16'h0001;
    end
    if (!v_norm && s.v_prev) begin
      next_s.post_cnt = s.r13;
    end else if (h_lead && s.post_cnt != 8'h00) begin
      next_s.post_cnt = s.post_cnt - 8'h01;
    end
    // internal clamp from hsync leading edge
    case (s.cst)
      SCC_CL_WAIT: begin
        if (s.ccnt <= 8'h01) begin
          next_s.cst  = (clamp_len == 8'h00) ? SCC_CL_IDLE : SCC_CL_ON;
          next_s.ccnt = clamp_len;
        end else begin
          next_s.ccnt = s.ccnt - 8'h01;
        end
      end
      SCC_CL_ON: begin
        if (s.ccnt <= 8'h01) begin
          next_s.cst = SCC_CL_IDLE;
        end
        next_s.ccnt = s.ccnt - 8'h01;
      end
      default: begin
        next_s.cst = SCC_CL_IDLE;
      end
    endcase
    if (h_lead) begin
      next_s.cst  = SCC_CL_WAIT;
      next_s.ccnt = clamp_place;
    end
    next_s.hs = h_norm ^ s.r0e[`SCC_B_HPOL];
    next_s.gs = g_norm ^ s.r0e[`SCC_B_HPOL];
    next_s.vs = v_norm ^ !s.r0e[`SCC_B_VNINV];
    next_s.cl = s.r0f[`SCC_B_CLSRC] ? clamp_x : clamp_i;
    next_s.co = s.r0f[`SCC_B_COSEL] ? coast_v : coast_p;
    // seek only when allowed and no sync
    next_s.sk = s.r0f[`SCC_B_SEEK] && !(h_act || g_act || v_act);
    next_s.pd = !s.r0f[`SCC_B_SLEEP];
  end

  // ----------------------------------------
  // state register
  // ----------------------------------------
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      s     <= '0;
      s.r0e <= `SCC_R_SYNC;
      s.r0f <= `SCC_R_CCP;
      s.r10 <= `SCC_R_SLICE;
      s.r11 <= `SCC_R_SEP;
      s.r12 <= `SCC_R_LEAD;
      s.r13 <= `SCC_R_TRAIL;
      s.cst <= SCC_CL_IDLE;
      s.pd  <= 1'b0;
    end else begin
      s <= next_s;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign reg_rdata               = s.rdata;
  assign hsync_out               = s.hs;
  assign green_embedded_sync_out = s.gs;
  assign vsync_out               = s.vs;
  assign clamp_out               = s.cl;
  assign coast_out               = s.co;
  assign seek_out                = s.sk;
  assign power_down              = s.pd;
  assign clamp_mid               = s.r10[2:0];
  assign slicer_code             = s.r10[`SCC_B_SLC_HI:`SCC_B_SLC_LO];

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  property p_hpol;
    ##1 (hsync_out == ($past(h_norm) ^ $past(s.r0e[`SCC_B_HPOL])));
  endproperty
  a_hpol: assert property (p_hpol) else $error("hsync polarity");
  property p_hovr;
    s.r0e[`SCC_B_HOVR] |-> (h_src == s.r0e[`SCC_B_HSEL]);
  endproperty
  a_hovr: assert property (p_hovr) else $error("hsync override");
  property p_hauto;
    (!s.r0e[`SCC_B_HOVR] && g_act && !h_act) |-> h_src;
  endproperty
  a_hauto: assert property (p_hauto) else $error("hsync auto");
  property p_vauto;
    (!s.r0e[`SCC_B_VOVR] && v_act) |=> ($past(v_src) == 1'b0);
  endproperty
  a_vauto: assert property (p_vauto) else $error("vsync auto");
  property p_pd;
    ##1 (power_down != $past(s.r0f[`SCC_B_SLEEP]));
  endproperty
  a_pd: assert property (p_pd) else $error("power-down");
  property p_seek;
    !s.r0f[`SCC_B_SEEK] |=> !seek_out;
  endproperty
  a_seek: assert property (p_seek) else $error("seek disallowed");
  property p_xclamp;
    (s.r0f[`SCC_B_CLSRC] && s.r0f[`SCC_B_CLPOL]) |=> (clamp_out != $past(k_lvl));
  endproperty
  a_xclamp: assert property (p_xclamp) else $error("ext clamp");
  property p_sep;
    $changed(s.sep_out) |-> ($past(s.sep_cnt) >= $past(s.r11));
  endproperty
  a_sep: assert property (p_sep) else $error("separator early");
  property p_iclamp;
    (s.cst == SCC_CL_ON && !s.r0f[`SCC_B_CLSRC]) |=> clamp_out;
  endproperty
  a_iclamp: assert property (p_iclamp) else $error("int clamp");

  c_clamp: cover property (s.cst == SCC_CL_ON);
  c_coast: cover property ($rose(coast_out));
  c_sep:   cover property ($rose(s.sep_out));
endmodule // scc_sync_ctrl
`default_nettype wire

// File: verif/scc_sync_src.sv
/*
  scc_sync_src: far-side graphics source making hsync, green-embedded
  sync and vsync pulses, all positive going.
  assumes ref_clk as time base; enables come from the bench.
*/
`timescale 1ns/100ps
`default_nettype none
module scc_sync_src #(
  parameter int HPER  = 40, // line length, cycles
  parameter int HW    = 4,  // sync pulse width, cycles
  parameter int LINES = 8,  // lines per frame
  parameter int VW    = 2   // vsync width, lines
) (
  input  wire logic ref_clk,
  input  wire logic rst_n,
  input  wire logic en_h,
  input  wire logic en_g,
  input  wire logic en_v,
  output logic      hsync,
  output logic      green,
  output logic      vsync
);
  int hc; // position in line
  int lc; // line in frame
  // line and frame timing; a disabled source sits steady low
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      hc    <= 0;
      lc    <= 0;
      hsync <= 1'b0;
      green <= 1'b0;
      vsync <= 1'b0;
    end else begin
      hc    <= (hc == HPER - 1) ? 0 : hc + 1;
      if (hc == HPER - 1) begin
        lc <= (lc == LINES - 1) ? 0 : lc + 1;
      end
      hsync <= en_h && (hc < HW);
      green <= en_g && (hc < HW);
      vsync <= en_v && (lc < VW);
    end
  end
endmodule // scc_sync_src
`default_nettype wire

// File: verif/sync_clamp_coast_control_bench.sv
/*
  sync_clamp_coast_control_bench: self-checking bench of scc_sync_ctrl.
  assumes scc_sync_src as far-side source and a short activity window.
*/
`timescale 1ns/100ps
`default_nettype none
`include "scc_params.svh"
module sync_clamp_coast_control_bench;
  import scc_pkg::*;
  // ----------------------------------------
  // signals
  // ----------------------------------------
  localparam int SET = 1200; // settle after a change, cycles
  logic       ref_clk     = 1'b0;
  logic       rst_n       = 1'b0;
  logic [7:0] reg_addr    = 8'h00;
  logic       reg_wr      = 1'b0;
  logic [7:0] reg_wdata   = 8'h00;
  logic       reg_rd      = 1'b0;
  logic       clamp_pin   = 1'b1;
  logic       coast_pin   = 1'b0;
  logic [7:0] clamp_place = 8'h0a;
  logic [7:0] clamp_len   = 8'h05;
  logic       en_h        = 1'b1;
  logic       en_g        = 1'b0;
  logic       en_v        = 1'b1;
  logic       clr         = 1'b0;
  logic       hs, gs, vs, h_o, g_o, v_o, cl_o, co_o, seek_o, pd_o;
  logic [7:0] reg_rdata;
  logic [2:0] clamp_mid;
  logic [4:0] slicer_code;
  int         n_fail = 0, checks_done = 0, cyc = 0;
  int         c_h, c_g, c_v, c_cl, c_co;
  // clock
  initial begin
    forever #2.5 ref_clk = ~ref_clk;
  end
  scc_sync_src u_scc_sync_src (.ref_clk(ref_clk), .rst_n(rst_n), .en_h(en_h),
    .en_g(en_g), .en_v(en_v), .hsync(hs), .green(gs), .vsync(vs));
  scc_sync_ctrl #(.DET_WIN(512)) u_scc_sync_ctrl (.ref_clk(ref_clk), .rst_n(rst_n),
    .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .hsync_pin(hs), .green_embedded_sync_pin(gs),
    .vsync_pin(vs), .clamp_pin(clamp_pin), .coast_pin(coast_pin),
    .clamp_place(clamp_place), .clamp_len(clamp_len), .hsync_out(h_o),
    .green_embedded_sync_out(g_o), .vsync_out(v_o), .clamp_out(cl_o),
    .clamp_mid(clamp_mid), .slicer_code(slicer_code), .coast_out(co_o),
    .seek_out(seek_o), .power_down(pd_o));
  // high-time counters and hang limit
  always @(posedge ref_clk) begin
    cyc  <= cyc + 1;
    c_h  <= clr ? 0 : c_h + (h_o ? 1 : 0);
    c_g  <= clr ? 0 : c_g + (g_o ? 1 : 0);
    c_v  <= clr ? 0 : c_v + (v_o ? 1 : 0);
    c_cl <= clr ? 0 : c_cl + (cl_o ? 1 : 0);
    c_co <= clr ? 0 : c_co + (co_o ? 1 : 0);
    if (cyc == 40000) begin
      n_fail++;
      finish_test();
    end
  end
  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic chk_rng(input int got, input int lo, input int hi);
    checks_done++;
    if (got < lo || got > hi) begin
      n_fail++;
      $display("unexpected at %0t: count %0d not in %0d..%0d", $time, got, lo, hi);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1;
    chk8(reg_rdata & m, e);
  endtask
  task automatic meas(input int n);
    @(posedge ref_clk);
    clr <= 1'b1;
    @(posedge ref_clk);
    clr <= 1'b0;
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  task automatic done(input string s);
    $display("test %s finished, failures %0d", s, n_fail);
  endtask
  task automatic finish_test();
    $display("checks %0d, failures %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_regs();
    logic [7:0] dv [6] = '{8'h00, 8'h4e, 8'hb8, 8'h20, 8'h00, 8'h00};
    for (int i = 0; i < 6; i++) rd(8'h0e + 8'(i), 8'hff, dv[i]);
    chk8({3'h0, slicer_code}, 8'd23);
    chk8({5'h0, clamp_mid}, 8'h00);
    wr(8'h10, 8'h5d);
    repeat (2) @(posedge ref_clk);
    #1;
    chk8({3'h0, slicer_code}, 8'h0b);
    chk8({5'h0, clamp_mid}, 8'h05);
    for (int i = 0; i < 3; i++) begin
      wr(8'h11 + 8'(i), 8'ha5);
      rd(8'h11 + 8'(i), 8'hff, 8'ha5);
      wr(8'h11 + 8'(i), dv[i + 3]);
    end
    rd(8'h20, 8'hff, 8'h00);
    wr(8'h10, 8'hb8);
    done("regs");
  endtask
  task automatic t_hsrc();
    logic [1:0] en [6] = '{2'b10, 2'b01, 2'b11, 2'b11, 2'b01, 2'b10};
    logic [7:0] cf [6] = '{8'h00, 8'h00, 8'h08, 8'h00, 8'h10, 8'h18};
    logic [7:0] ex [6] = '{8'h80, 8'h42, 8'hc2, 8'h82, 8'h02, 8'hc0};
    for (int i = 0; i < 6; i++) begin
      @(posedge ref_clk);
      en_h <= en[i][1];
      en_g <= en[i][0];
      wr(8'h0e, cf[i]);
      repeat (SET) @(posedge ref_clk);
      rd(8'h14, 8'hc2, ex[i]);
    end
    done("hsync source");
  endtask
  task automatic t_vsrc();
    logic       ev [4] = '{1'b1, 1'b0, 1'b0, 1'b1};
    logic [7:0] cf [4] = '{8'h00, 8'h00, 8'h02, 8'h03};
    logic [7:0] ex [4] = '{8'h10, 8'h08, 8'h00, 8'h18};
    for (int i = 0; i < 4; i++) begin
      @(posedge ref_clk);
      en_v <= ev[i];
      wr(8'h0e, cf[i]);
      repeat (SET) @(posedge ref_clk);
      rd(8'h14, 8'h18, ex[i]);
    end
    done("vsync source");
  endtask
  task automatic t_pol();
    @(posedge ref_clk);
    en_g <= 1'b1;
    wr(8'h0e, 8'h00);
    repeat (SET) @(posedge ref_clk);
    meas(640);
    chk_rng(c_h, 56, 72);
    chk_rng(c_g, 56, 72);
    chk_rng(c_v, 464, 496);
    wr(8'h0e, 8'h24);
    repeat (400) @(posedge ref_clk);
    meas(640);
    chk_rng(c_h, 568, 584);
    chk_rng(c_g, 568, 584);
    chk_rng(c_v, 144, 176);
    wr(8'h0e, 8'h00);
    done("polarity");
  endtask
  task automatic t_clamp();
    repeat (400) @(posedge ref_clk);
    meas(640);
    chk_rng(c_cl, 78, 84);
    @(posedge ref_clk);
    clamp_len <= 8'h00;
    repeat (100) @(posedge ref_clk);
    meas(640);
    chk_rng(c_cl, 0, 0);
    for (int p = 0; p < 2; p++) begin
      wr(8'h0f, (p == 1) ? 8'hc2 : 8'h82);
      for (int l = 0; l < 2; l++) begin
        @(posedge ref_clk);
        clamp_pin <= l[0];
        repeat (10) @(posedge ref_clk);
        #1;
        chk8({7'h0, cl_o}, 8'(l != p));
      end
    end
    @(posedge ref_clk);
    clamp_len <= 8'h05;
    clamp_pin <= 1'b1;
    done("clamp");
  endtask
  task automatic t_coast();
    for (int p = 0; p < 2; p++) begin
      wr(8'h0f, (p == 1) ? 8'h5a : 8'h52);
      for (int l = 0; l < 2; l++) begin
        @(posedge ref_clk);
        coast_pin <= l[0];
        repeat (10) @(posedge ref_clk);
        #1;
        chk8({7'h0, co_o}, 8'(l == p));
      end
    end
    done("coast pin");
  endtask
  task automatic t_prepost();
    int c0;
    wr(8'h0f, 8'h62);
    repeat (700) @(posedge ref_clk);
    meas(640);
    c0 = c_co;
    chk_rng(c0, 144, 176);
    wr(8'h13, 8'h03);
    repeat (700) @(posedge ref_clk);
    meas(640);
    chk_rng(c_co - c0, 220, 260);
    wr(8'h13, 8'h00);
    wr(8'h12, 8'h02);
    repeat (700) @(posedge ref_clk);
    meas(640);
    chk_rng(c_co - c0, 140, 180);
    wr(8'h12, 8'h00);
    done("pre and post coast");
  endtask
  task automatic t_power();
    @(posedge ref_clk);
    en_h <= 1'b0;
    en_g <= 1'b0;
    en_v <= 1'b0;
    wr(8'h0f, 8'h4e);
    repeat (SET) @(posedge ref_clk);
    #1;
    chk8({7'h0, seek_o}, 8'h01);
    wr(8'h0f, 8'h4a);
    repeat (3) @(posedge ref_clk);
    #1;
    chk8({7'h0, seek_o}, 8'h00);
    chk8({7'h0, pd_o}, 8'h00);
    wr(8'h0f, 8'h4c);
    repeat (3) @(posedge ref_clk);
    #1;
    chk8({7'h0, pd_o}, 8'h01);
    done("seek and power");
  endtask
  // main sequence
  initial begin
    repeat (12) @(posedge ref_clk);
    rst_n <= 1'b1;
    t_regs();
    t_hsrc();
    t_vsrc();
    t_pol();
    t_clamp();
    t_coast();
    t_prepost();
    t_power();
    finish_test();
  end
endmodule // sync_clamp_coast_control_bench
`default_nettype wire
